// file: verilog/msm_pkg.sv
`default_nettype none
package msm_pkg;
    // Register byte offsets
    localparam logic [15:0] OFS_DATA = 16'ha018;
    localparam logic [15:0] OFS_CTRL = 16'ha01c;
    localparam logic [15:0] OFS_CAM  = 16'ha028;
    localparam logic [15:0] OFS_DROP = 16'ha03c;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_8000;
    localparam logic [2:0]  DIV_RST  = 3'h4;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [15:0] DROP_RST = 16'h0000;
    // Control field positions
    localparam int B_REG  = 0;
    localparam int B_PHY  = 5;
    localparam int B_WR   = 10;
    localparam int B_BUSY = 11;
    localparam int B_OMIT = 12;
    localparam int B_DIV  = 13;
    // Clock divider: period = 2*code + 16, so half period = code + 8
    localparam logic [3:0] MDC_HALF_BASE = 4'h8;
    // Frame layout
    localparam logic [4:0] LAST_BIT = 5'h1f;
    localparam logic [4:0] TA_BIT   = 5'h0e;
    localparam logic [1:0] SOF      = 2'h1;
    localparam logic [1:0] OP_WR    = 2'h1;
    localparam logic [1:0] OP_RD    = 2'h2;
    localparam logic [1:0] TA_WR    = 2'h2;
    localparam logic [1:0] TA_RD    = 2'h3;
    // Counter, lookup limit, bus size and engine modes
    localparam logic [15:0] ROLL_FROM = 16'h7fff;
    localparam int          CAM_MAX   = 21;
    localparam logic [2:0]  HSIZE_WORD = 3'h2;
    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_PRE  = 2'h1,
        S_XFER = 2'h3
    } msm_mode_t;
endpackage
`default_nettype wire

// file: verilog/msm_mdc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface msm_mdc_if;
    logic       run;
    logic [2:0] div;
    logic       mdc;
    logic       rise;
    logic       fall;
    modport gen (input run, input div, output mdc, output rise, output fall);
    modport use_clk (output run, output div, input mdc, input rise, input fall);
endinterface
`default_nettype wire

// file: verilog/msm_mdc_gen.sv
`timescale 1ns/1ps
`default_nettype none
module msm_mdc_gen (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    msm_mdc_if.gen     m
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       mdc;
        logic       rise;
        logic       fall;
        logic [3:0] hi_len;
    } msm_gen_t;

    msm_gen_t   s;
    msm_gen_t   next_s;
    logic [3:0] half;

    assign half = {1'b0, m.div} + msm_pkg::MDC_HALF_BASE;

    always_comb begin
        next_s      = s;
        next_s.rise = 1'b0;
        next_s.fall = 1'b0;
        if (!m.run) begin
            // Parked low between frames
            next_s.cnt = 4'h0;
            next_s.mdc = 1'b0;
        end else if (s.cnt == half - 4'h1) begin
            next_s.cnt  = 4'h0;
            next_s.mdc  = !s.mdc;
            next_s.rise = !s.mdc;
            next_s.fall = s.mdc;
        end else begin
            next_s.cnt = s.cnt + 4'h1;
        end
        next_s.hi_len = s.mdc ? s.hi_len + 4'h1 : 4'h0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign m.mdc  = s.mdc;
    assign m.rise = s.rise;
    assign m.fall = s.fall;

    chk_mdc_high_len: assert property (@(posedge clk_i) disable iff (rst_i)
        ($fell(s.mdc) && m.run) |-> (s.hi_len == half))
        else $error("mdc high phase length wrong");
endmodule // msm_mdc_gen
`default_nettype wire

// file: verilog/msm_top.sv
// Functional notes
// - Sixteen-bit management data register holds write value or read-back value.
// - Control bits 4..0 select one of 32 PHY registers.
// - Control bits 9..5 give the five-bit PHY address.
// - Control bit 10 set means write, clear means read.
// - Writing bit 11 starts a transfer; hardware clears it when done.
// - Control bit 12 set omits the preamble; clear sends it.
// - Management clock period is twice bits 15..13 plus 16 clocks.
// - Divider field resets to 100, control reads 0x8000 after reset.
// - Management settings never touch frame transmit or receive logic.
// - 21-bit mask marks lookup entries 0..20 valid.
// - Mask bits above the implemented entries are ignored.
// - Reading the dropped counter returns its value and clears it.
// - Counting from 0x7FFF to 0x8000 raises the rollover flag.
// - Software may preload the counter to approach rollover sooner.
// - Overflow, parity error or receive disabled counts a dropped packet.
// - Packets rejected by address lookup are never counted.
// - Alignment error at packet end counts.
// - Checksum error counts only when no other error is reported.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module msm_top #(
    parameter int CAM_ENTRIES = 21
) (
    input  wire logic                   MCLK_I,
    input  wire logic                   RST_I,
    input  wire logic                   HSEL_I,
    input  wire logic [31:0]            HADDR_I,
    input  wire logic [1:0]             HTRANS_I,
    input  wire logic                   HWRITE_I,
    input  wire logic [2:0]             HSIZE_I,
    input  wire logic [31:0]            HWDATA_I,
    input  wire logic                   HREADY_I,
    output logic                        HREADYOUT_O,
    output logic                        HRESP_O,
    output logic [31:0]                 HRDATA_O,
    output logic                        MDC_O,
    input  wire logic                   MDIO_I,
    output logic                        MDIO_O,
    output logic                        MDIO_OE_N_O,
    input  wire logic                   RX_END_I,
    input  wire logic                   RX_ALIGN_ERR_I,
    input  wire logic                   RX_CRC_ERR_I,
    input  wire logic                   RX_OVERFLOW_I,
    input  wire logic                   RX_PARITY_ERR_I,
    input  wire logic                   RX_EN_I,
    input  wire logic                   RX_CAM_REJECT_I,
    output logic [CAM_ENTRIES-1:0]      CAM_VALID_O,
    output logic                        ROLL_SET_O
);
    localparam int BUSY_LIMIT = 2000;

    generate
        if (CAM_ENTRIES < 1 || CAM_ENTRIES > msm_pkg::CAM_MAX) begin : g_bad
            $error("CAM_ENTRIES out of range");
        end
    endgenerate

    typedef struct packed {
        logic                   ap_v;
        logic                   rd_w;
        logic [15:0]            ap_ad;
        logic [31:0]            rdata;
        logic [15:0]            data;
        logic [4:0]             reg_a;
        logic [4:0]             phy_a;
        logic                   wr;
        logic                   busy;
        logic                   omit;
        logic [2:0]             div;
        logic [CAM_ENTRIES-1:0] cam;
        logic [15:0]            drop;
        logic                   roll;
        msm_pkg::msm_mode_t     mode;
        logic [4:0]             bits;
        logic [31:0]            sh;
        logic                   mdo;
        logic                   oe_n;
        logic                   sy1;
        logic                   sy2;
        logic [10:0]            busy_t;
    } msm_state_t;

    msm_state_t s;
    msm_state_t next_s;
    msm_mdc_if  mif ();

    logic        acc;
    logic        wr_ph;
    logic        rd_ph;
    logic        rd_clr;
    logic        inc;
    logic [15:0] base;

    // Word-aligned hit on one register
    function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
        return a[15:2] == o[15:2];
    endfunction

    function automatic logic [31:0] rd_mux(input msm_state_t st);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (hit(st.ap_ad, msm_pkg::OFS_DATA)) begin
            r = {16'h0000, st.data};
        end else if (hit(st.ap_ad, msm_pkg::OFS_CTRL)) begin
            r = {16'h0000, st.div, st.omit, st.busy, st.wr, st.phy_a, st.reg_a};
        end else if (hit(st.ap_ad, msm_pkg::OFS_CAM)) begin
            r = 32'(st.cam);
        end else if (hit(st.ap_ad, msm_pkg::OFS_DROP)) begin
            r = {16'h0000, st.drop};
        end
        return r;
    endfunction

    msm_mdc_gen u_mdc (
        .clk_i (MCLK_I),
        .rst_i (RST_I),
        .m     (mif.gen)
    );

    assign mif.run = (s.mode != msm_pkg::S_IDLE);
    assign mif.div = s.div;

    // Bus decode; only whole-word transfers are taken
    assign acc   = HSEL_I && HTRANS_I[1] && HREADY_I && (HSIZE_I == msm_pkg::HSIZE_WORD);
    assign wr_ph = s.ap_v;
    assign rd_ph = s.rd_w;
    assign rd_clr = rd_ph && hit(s.ap_ad, msm_pkg::OFS_DROP);

    // One count per finished, lookup-accepted packet that shows an error or arrives with receive disabled
    assign inc = RX_END_I && !RX_CAM_REJECT_I && (
        RX_OVERFLOW_I || RX_PARITY_ERR_I || !RX_EN_I
        || RX_ALIGN_ERR_I
        || (RX_CRC_ERR_I && !RX_ALIGN_ERR_I && !RX_OVERFLOW_I && !RX_PARITY_ERR_I));

    // Preload or clear forms the base; an event in the same cycle still counts
    always_comb begin
        base = s.drop;
        if (rd_clr) begin
            base = msm_pkg::DROP_RST;
        end else if (wr_ph && hit(s.ap_ad, msm_pkg::OFS_DROP)) begin
            base = HWDATA_I[15:0];
        end
    end

    always_comb begin
        next_s      = s;
        next_s.roll = 1'b0;
        next_s.sy1  = MDIO_I;
        next_s.sy2  = s.sy1;

        // Address phase capture
        if (acc) begin
            next_s.ap_ad = HADDR_I[15:0];
        end
        next_s.ap_v = acc && HWRITE_I;
        next_s.rd_w = acc && !HWRITE_I;

        // Read data is taken in the single wait cycle
        if (rd_ph) begin
            next_s.rdata = rd_mux(s);
        end

        // Write data phase; settings only feed the management engine
        if (wr_ph && !s.busy) begin
            if (hit(s.ap_ad, msm_pkg::OFS_DATA)) begin
                next_s.data = HWDATA_I[15:0];
            end
            if (hit(s.ap_ad, msm_pkg::OFS_CTRL)) begin
                next_s.reg_a = HWDATA_I[msm_pkg::B_REG +: 5];
                next_s.phy_a = HWDATA_I[msm_pkg::B_PHY +: 5];
                next_s.wr    = HWDATA_I[msm_pkg::B_WR];
                next_s.busy  = HWDATA_I[msm_pkg::B_BUSY];
                next_s.omit  = HWDATA_I[msm_pkg::B_OMIT];
                next_s.div   = HWDATA_I[msm_pkg::B_DIV +: 3];
            end
        end
        if (wr_ph && hit(s.ap_ad, msm_pkg::OFS_CAM)) begin
            next_s.cam = HWDATA_I[CAM_ENTRIES-1:0];
        end

        next_s.drop = base + {15'h0000, inc};
        next_s.roll = inc && (base == msm_pkg::ROLL_FROM);

        // Management frame engine
        case (s.mode)
            msm_pkg::S_IDLE: begin
                if (s.busy) begin
                    next_s.bits = 5'h00;
                    next_s.sh   = {msm_pkg::SOF,
                                   s.wr ? msm_pkg::OP_WR : msm_pkg::OP_RD,
                                   s.phy_a, s.reg_a,
                                   s.wr ? msm_pkg::TA_WR : msm_pkg::TA_RD,
                                   s.wr ? s.data : 16'hffff};
                    next_s.oe_n = 1'b0;
                    if (s.omit) begin
                        next_s.mode = msm_pkg::S_XFER;
                        next_s.mdo  = 1'b0;
                    end else begin
                        next_s.mode = msm_pkg::S_PRE;
                        next_s.mdo  = 1'b1;
                    end
                end
            end
            msm_pkg::S_PRE: begin
                if (mif.rise) begin
                    next_s.bits = s.bits + 5'h01;
                    if (s.bits == msm_pkg::LAST_BIT) begin
                        next_s.mode = msm_pkg::S_XFER;
                        next_s.bits = 5'h00;
                    end
                end
                if (mif.fall) begin
                    next_s.mdo = 1'b1;
                end
            end
            msm_pkg::S_XFER: begin
                // Drive on the falling edge, sample on the rising edge
                if (mif.fall) begin
                    next_s.mdo  = s.sh[31];
                    next_s.oe_n = !s.wr && (s.bits >= msm_pkg::TA_BIT);
                end
                if (mif.rise) begin
                    next_s.sh   = {s.sh[30:0], s.sy2};
                    next_s.bits = s.bits + 5'h01;
                    if (s.bits == msm_pkg::LAST_BIT) begin
                        if (!s.wr) begin
                            next_s.data = {s.sh[14:0], s.sy2};
                        end
                        next_s.busy = 1'b0;
                        next_s.mode = msm_pkg::S_IDLE;
                        next_s.oe_n = 1'b1;
                        next_s.mdo  = 1'b1;
                    end
                end
            end
            default: begin
                next_s.mode = msm_pkg::S_IDLE;
                next_s.oe_n = 1'b1;
            end
        endcase

        next_s.busy_t = s.busy ? s.busy_t + 11'h001 : 11'h000;
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            s      <= '0;
            s.div  <= msm_pkg::DIV_RST;
            s.data <= msm_pkg::DATA_RST;
            s.drop <= msm_pkg::DROP_RST;
            s.mode <= msm_pkg::S_IDLE;
            s.mdo  <= 1'b1;
            s.oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign HREADYOUT_O = !s.rd_w;
    assign HRESP_O     = 1'b0;
    assign HRDATA_O    = s.rdata;
    assign MDC_O       = mif.mdc;
    assign MDIO_O      = s.mdo;
    assign MDIO_OE_N_O = s.oe_n;
    assign CAM_VALID_O = s.cam;
    assign ROLL_SET_O  = s.roll;

    chk_ctrl_after_reset: assert property (@(posedge MCLK_I) disable iff (RST_I)
        $fell(RST_I) |-> ({s.div, s.omit, s.busy, s.wr, s.phy_a, s.reg_a}
                          == msm_pkg::CTRL_RST[15:0]))
        else $error("control not at reset value");

    chk_busy_ends: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s.busy_t < 11'(BUSY_LIMIT))
        else $error("management transfer never finished");

    chk_busy_start: assert property (@(posedge MCLK_I) disable iff (RST_I)
        ($rose(s.busy) && s.mode == msm_pkg::S_IDLE) |=> (s.mode != msm_pkg::S_IDLE))
        else $error("transfer did not start");

    chk_preamble_omit: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (s.mode == msm_pkg::S_IDLE && s.busy && s.omit) |=> (s.mode == msm_pkg::S_XFER))
        else $error("preamble sent while omitted");

    chk_preamble_ones: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (s.mode == msm_pkg::S_PRE) |-> (s.mdo && !s.oe_n))
        else $error("preamble bit not driven one");

    chk_write_drives: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (s.mode == msm_pkg::S_XFER && s.wr) |-> !s.oe_n)
        else $error("write frame released the data line");

    chk_read_release: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (s.mode == msm_pkg::S_XFER && !s.wr && mif.fall && s.bits >= msm_pkg::TA_BIT)
        |=> s.oe_n)
        else $error("read frame kept driving after turnaround");

    chk_read_data: assert property (@(posedge MCLK_I) disable iff (RST_I)
        ($fell(s.busy) && !s.wr) |-> (s.data == {$past(s.sh[14:0]), $past(s.sy2)}))
        else $error("read data not stored at completion");

    chk_read_clears: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (rd_clr && !inc) |=> (s.drop == 16'h0000 && s.rdata[15:0] == $past(s.drop)))
        else $error("counter read did not clear");

    chk_preload: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (wr_ph && hit(s.ap_ad, msm_pkg::OFS_DROP) && !inc) |=>
        (s.drop == $past(HWDATA_I[15:0])))
        else $error("counter preload lost");

    chk_roll_flag: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (inc && !rd_clr && !wr_ph && s.drop == msm_pkg::ROLL_FROM) |=>
        (ROLL_SET_O && s.drop == 16'h8000))
        else $error("rollover flag missing");

    chk_reject_ignored: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (RX_END_I && RX_CAM_REJECT_I && !rd_ph && !wr_ph) |=> $stable(s.drop))
        else $error("rejected packet counted");

    chk_crc_only: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (RX_END_I && !RX_CAM_REJECT_I && RX_CRC_ERR_I && RX_EN_I && !rd_ph && !wr_ph
         && s.drop != 16'hffff) |=> (s.drop == $past(s.drop) + 16'h0001))
        else $error("packet with error not counted once");

    chk_cam_mask: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (wr_ph && hit(s.ap_ad, msm_pkg::OFS_CAM)) |=> (CAM_VALID_O == $past(HWDATA_I[CAM_ENTRIES-1:0])))
        else $error("entry mask write lost");

    chk_roll_value: assert property (@(posedge MCLK_I) disable iff (RST_I)
        ROLL_SET_O |-> (s.drop == 16'h8000))
        else $error("rollover flag without rollover value");

    chk_mdc_parked: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (s.mode == msm_pkg::S_IDLE && $past(s.mode) == msm_pkg::S_IDLE) |-> !MDC_O)
        else $error("management clock runs while idle");

    chk_line_idle: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (s.mode == msm_pkg::S_IDLE && !s.busy) |-> (MDIO_OE_N_O && MDIO_O))
        else $error("data line not released while idle");

    chk_busy_refuse: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (wr_ph && s.busy && hit(s.ap_ad, msm_pkg::OFS_CTRL))
        |=> ($stable(s.div) && $stable(s.phy_a) && $stable(s.reg_a)))
        else $error("control changed during a transfer");
endmodule // msm_top
`default_nettype wire

// file: tb/msm_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module msm_phy_model (
    input  wire logic        mdc_i,
    input  wire logic        mdio_i,
    input  wire logic [15:0] read_word_i,
    output logic             mdio_o,
    output logic             mdio_oe_n_o
);
    int          cnt;
    int          ones;
    int          pre_ones;
    int          period_ns;
    logic        prev;
    logic        is_rd;
    logic [31:0] frame;
    realtime     t_last;

    initial begin
        cnt = 0;
        ones = 0;
        prev = 1'b1;
        is_rd = 1'b0;
        t_last = 0;
        mdio_o = 1'b1;
        mdio_oe_n_o = 1'b1;
    end

    // Frame decode on the rising management clock edge
    always @(posedge mdc_i) begin
        if (t_last > 0) period_ns = int'($realtime - t_last);
        t_last = $realtime;
        if (cnt == 0) begin
            if (prev == 1'b0 && mdio_i == 1'b1) begin
                cnt = 2;
                pre_ones = ones;
                frame = 32'h0000_0001;
            end else if (mdio_i == 1'b1) begin
                ones++;
            end
            prev = mdio_i;
        end else begin
            frame = {frame[30:0], mdio_i};
            cnt++;
            if (cnt == 4) is_rd = (frame[1:0] == 2'h2);
            if (cnt == 32) begin
                cnt = 0;
                ones = 0;
                prev = 1'b1;
            end
        end
    end

    // Answer launched on the fall, so it is stable a half period before sampling
    always @(negedge mdc_i) begin
        if (is_rd && cnt >= 15 && cnt <= 31) begin
            mdio_oe_n_o = 1'b0;
            mdio_o = (cnt == 15) ? 1'b0 : read_word_i[31-cnt];
        end else begin
            mdio_oe_n_o = 1'b1;
            mdio_o = 1'b1;
            if (cnt == 0) is_rd = 1'b0;
        end
    end
endmodule // msm_phy_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int NCAM = 16;
    localparam logic [31:0] MASK = 32'h0000_ffff;
    logic        MCLK_I, RST_I, HSEL_I, HWRITE_I, RX_END_I, RX_EN_I;
    logic        RX_ALIGN_ERR_I, RX_CRC_ERR_I, RX_OVERFLOW_I, RX_PARITY_ERR_I, RX_CAM_REJECT_I;
    logic [31:0] HADDR_I, HWDATA_I, HRDATA_O;
    logic [1:0]  HTRANS_I;
    logic [2:0]  HSIZE_I;
    logic        HREADYOUT_O, HRESP_O, MDC_O, MDIO_O, MDIO_OE_N_O, ROLL_SET_O;
    logic [NCAM-1:0] CAM_VALID_O;
    logic        phy_d, phy_oe_n, mdio_line;
    logic [15:0] phy_word;
    logic [2:0]  hsz;
    int          fail_count, n_checks, roll_cnt;

    // Open-drain style line with a pull-up when nobody drives
    assign mdio_line = !MDIO_OE_N_O ? MDIO_O : (!phy_oe_n ? phy_d : 1'b1);

    msm_top #(.CAM_ENTRIES(NCAM)) i_msm_top (
        .MCLK_I(MCLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
        .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
        .HREADY_I(HREADYOUT_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
        .HRDATA_O(HRDATA_O), .MDC_O(MDC_O), .MDIO_I(mdio_line), .MDIO_O(MDIO_O),
        .MDIO_OE_N_O(MDIO_OE_N_O), .RX_END_I(RX_END_I), .RX_ALIGN_ERR_I(RX_ALIGN_ERR_I),
        .RX_CRC_ERR_I(RX_CRC_ERR_I), .RX_OVERFLOW_I(RX_OVERFLOW_I),
        .RX_PARITY_ERR_I(RX_PARITY_ERR_I), .RX_EN_I(RX_EN_I),
        .RX_CAM_REJECT_I(RX_CAM_REJECT_I), .CAM_VALID_O(CAM_VALID_O), .ROLL_SET_O(ROLL_SET_O));

    msm_phy_model i_msm_phy_model (
        .mdc_i(MDC_O), .mdio_i(mdio_line), .read_word_i(phy_word),
        .mdio_o(phy_d), .mdio_oe_n_o(phy_oe_n));

    initial begin
        MCLK_I = 1'b0;
        forever #25 MCLK_I = ~MCLK_I;
    end

    always @(posedge MCLK_I) if (ROLL_SET_O === 1'b1) roll_cnt++;

    task test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask

    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge MCLK_I);
            n++;
        end while (HREADYOUT_O !== 1'b1 && n < 20);
        if (HREADYOUT_O !== 1'b1) begin
            fail_count++;
            test_done();
        end
    endtask

    task bus(input logic w, input logic [15:0] ofs, input logic [31:0] wd,
             output logic [31:0] r);
        HSEL_I <= 1'b1;
        HTRANS_I <= 2'h2;
        HADDR_I <= {16'h0000, ofs};
        HWRITE_I <= w;
        HSIZE_I <= hsz;
        wait_rdy();
        HTRANS_I <= 2'h0;
        HWDATA_I <= wd;
        wait_rdy();
        r = HRDATA_O;
    endtask

    task wr(input logic [15:0] ofs, input logic [31:0] wd);
        logic [31:0] r;
        bus(1'b1, ofs, wd, r);
    endtask

    task rdc(input string name, input logic [15:0] ofs, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, ofs, 32'h0, r);
        check(name, r, exp);
    endtask

    task pkt(input logic [5:0] f);
        {RX_CAM_REJECT_I, RX_EN_I, RX_PARITY_ERR_I, RX_OVERFLOW_I, RX_CRC_ERR_I,
         RX_ALIGN_ERR_I} <= f;
        RX_END_I <= 1'b1;
        @(posedge MCLK_I);
        RX_END_I <= 1'b0;
        RX_EN_I <= 1'b1;
        repeat (3) @(posedge MCLK_I);
    endtask

    task t_reset;
        rdc("data reset", msm_pkg::OFS_DATA, 32'h0000_0000);
        rdc("ctrl reset", msm_pkg::OFS_CTRL, 32'h0000_8000);
        rdc("mask reset", msm_pkg::OFS_CAM, 32'h0000_0000);
        rdc("count reset", msm_pkg::OFS_DROP, 32'h0000_0000);
        check("hresp", {31'h0, HRESP_O}, 32'h0);
    endtask

    task t_regs;
        wr(msm_pkg::OFS_DATA, 32'hffff_c3a5);
        rdc("data rw", msm_pkg::OFS_DATA, 32'h0000_c3a5);
        // Sub-word transfers must leave the register alone
        hsz = 3'h0;
        wr(msm_pkg::OFS_DATA, 32'h0000_1111);
        hsz = msm_pkg::HSIZE_WORD;
        rdc("byte ignored", msm_pkg::OFS_DATA, 32'h0000_c3a5);
        wr(msm_pkg::OFS_CAM, 32'hffff_ffff);
        rdc("mask full", msm_pkg::OFS_CAM, MASK);
        check("mask out full", 32'(CAM_VALID_O), MASK);
        wr(msm_pkg::OFS_CAM, 32'h0015_5555);
        rdc("mask pattern", msm_pkg::OFS_CAM, 32'h0015_5555 & MASK);
        check("mask out", 32'(CAM_VALID_O), 32'h0015_5555 & MASK);
        wr(16'ha020, 32'h0000_1234);
        rdc("unmapped", 16'ha020, 32'h0000_0000);
    endtask

    // Write/read alternate; preamble and divider code vary per pass
    task t_mgmt(input logic [2:0] i);
        logic [31:0] ctl, r;
        logic [15:0] wd, exp_d;
        int n;
        wd = {i, 13'h0a5c};
        phy_word = {13'h1b3d, i};
        exp_d = i[0] ? wd : phy_word;
        ctl = {16'h0, i, i[1], 1'b1, i[0], 5'(i + 3'h3), 5'h1f - 5'(i)};
        wr(msm_pkg::OFS_DATA, {16'hffff, wd});
        wr(msm_pkg::OFS_CTRL, ctl);
        wr(msm_pkg::OFS_DATA, 32'h0000_0f0f);
        n = 0;
        do begin
            bus(1'b0, msm_pkg::OFS_CTRL, 32'h0, r);
            n++;
        end while (r[11] !== 1'b0 && n < 2000);
        if (r[11] !== 1'b0) begin
            fail_count++;
            test_done();
        end
        check("ctrl done", r, ctl & 32'hffff_f7ff);
        check("frame", i_msm_phy_model.frame,
              {2'h1, i[0] ? 2'h1 : 2'h2, ctl[9:5], ctl[4:0], 2'h2, exp_d});
        check("preamble", i_msm_phy_model.pre_ones, i[1] ? 0 : 32);
        check("mdc period", i_msm_phy_model.period_ns / 50, 2 * i + 16);
        rdc("data after", msm_pkg::OFS_DATA, {16'h0, exp_d});
        check("mdc idle", {MDC_O, MDIO_OE_N_O}, 32'h1);
    endtask

    task t_count;
        logic [5:0] tbl [8];
        tbl = '{6'h10, 6'h14, 6'h18, 6'h00, 6'h11, 6'h12, 6'h13, 6'h34};
        foreach (tbl[k]) begin
            pkt(tbl[k]);
            rdc("count", msm_pkg::OFS_DROP,
                32'(!tbl[k][5] && (tbl[k][3:0] != 4'h0 || !tbl[k][4])));
        end
        rdc("count clear", msm_pkg::OFS_DROP, 32'h0);
        wr(msm_pkg::OFS_DROP, 32'h0000_7ffe);
        pkt(6'h14);
        check("no roll", roll_cnt, 0);
        pkt(6'h14);
        check("roll", roll_cnt, 1);
        rdc("count roll", msm_pkg::OFS_DROP, 32'h0000_8000);
    endtask

    initial begin
        {HSEL_I, HWRITE_I, RX_END_I, RX_ALIGN_ERR_I, RX_CRC_ERR_I} = '0;
        {RX_OVERFLOW_I, RX_PARITY_ERR_I, RX_CAM_REJECT_I} = '0;
        {HADDR_I, HWDATA_I, HTRANS_I} = '0;
        HSIZE_I = msm_pkg::HSIZE_WORD;
        RX_EN_I = 1'b1;
        RST_I = 1'b1;
        phy_word = 16'h0;
        hsz = msm_pkg::HSIZE_WORD;
        fail_count = 0;
        n_checks = 0;
        roll_cnt = 0;
        repeat (8) @(posedge MCLK_I);
        RST_I <= 1'b0;
        @(posedge MCLK_I);
        t_reset();
        t_regs();
        for (int i = 0; i < 8; i++) t_mgmt(3'(i));
        t_count();
        test_done();
    end
endmodule // testbench
`default_nettype wire
